//--- src/mon_cfg_regs.svh
/*
 * register offsets, field positions, reset values and timing counts of
 * the monitor configuration and shunt result block.
 * assumes: included by the design modules by bare name; the package does not include it.
 */
`ifndef MON_CFG_REGS_SVH
`define MON_CFG_REGS_SVH

`define MON_PTR_SETUP      8'h00
`define MON_PTR_SHUNT      8'h01
`define MON_SETUP_RESET    16'h399F
`define MON_BIT_SOFT_RST   15
`define MON_BIT_BUS_RANGE  13
`define MON_GAIN_HI        12
`define MON_GAIN_LO        11
`define MON_BUS_CONV_HI    10
`define MON_BUS_CONV_LO    7
`define MON_SHUNT_CONV_HI  6
`define MON_SHUNT_CONV_LO  3
`define MON_MODE_HI        2
`define MON_MODE_LO        0
`define MON_FS_DIV8        16'h7D00
`define MON_FS_DIV4        16'h3E80
`define MON_FS_DIV2        16'h1F40
`define MON_FS_UNITY       16'h0FA0
`define MON_CLK_MHZ        125
`define MON_CONV_9B_US     84
`define MON_CONV_10B_US    148
`define MON_CONV_11B_US    276
`define MON_CONV_12B_US    532
`define MON_AVG_BASE_US    532

`endif

//--- src/mon_cfg_shunt.sv
// What this block does
// [R01] writing one to setup bit 15 resets all registers; bit self-clears
// [R02] bus range bit 13: 0 selects 16 V, 1 selects 32 V; reset one
// [R03] gain field 00 x1 40mV, 01 /2, 10 /4, 11 /8 320mV; shunt only
// [R04] gain field resets to divide-by-eight
// [R05] bits 10:7 set bus conversion resolution or averaging
// [R06] bits 6:3 set shunt conversion setting, same encoding as bus
// [R07] top bit zero: third ignored, 9..12 bit, 84..532 us
// [R08] codes 1001..1111 average 2..128 samples, 1.06 to 68.10 ms
// [R09] mode field resets to continuous shunt and bus
// [R10] 000 down, 100 off, 001..011 triggered, 101..111 continuous
// [R11] pointer 01h holds the latest shunt conversion
// [R12] shunt result sign bits follow gain, all equal
// [R13] negative shunt values are two's complement, sign extended
// [R14] /8 full scale 32000: 7D00h and 8300h
// [R15] /4 full scale 16000: 3E80h and C180h
// [R16] /2 full scale 8000: 1F40h and E0C0h
// [R17] x1 full scale 4000, minus reads F060h
// [R18] out-of-range shunt readings saturate at the gain's full scale
// [R19] registers move as two bytes, most significant first
// [R20] triggered mode converts once per setup write, then holds
/*
 * configuration register, conversion sequencer and shunt result of the
 * monitor; registers reached through a byte port from the serial front.
 * assumes: byte strobes come from the two-wire slave on clk; the analog
 * shunt sample arrives asynchronously and is synchronised here.
 */
`include "mon_cfg_regs.svh"
module mon_cfg_shunt (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        ptr_wr,
	input  wire logic [7:0]  ptr_data,
	input  wire logic        byte_wr,
	input  wire logic [7:0]  byte_wdata,
	input  wire logic        rd_start,
	input  wire logic        byte_rd,
	input  wire logic [16:0] shunt_sample,
	output logic      [7:0]  rd_byte,
	output logic      [15:0] setup_reg_out,
	output mon_pkg::mon_mode_t mode_out,
	output logic             conv_busy,
	output logic             shunt_conv_pulse,
	output logic             bus_conv_pulse
);
	import mon_pkg::*;

	// conversion time of one setting in cycles
	function automatic logic [23:0] conv_cycles(input logic [3:0] code);
		logic [31:0] us;
		us = 32'd0;
		if (!code[3]) begin
			case (code[1:0]) // [R07]
				2'h0:    us = `MON_CONV_9B_US;
				2'h1:    us = `MON_CONV_10B_US;
				2'h2:    us = `MON_CONV_11B_US;
				default: us = `MON_CONV_12B_US;
			endcase
		end else begin
			// averaging: base sample time times 2^n
			us = `MON_AVG_BASE_US << code[2:0]; // [R08]
		end
		conv_cycles = 24'(us * `MON_CLK_MHZ);
	endfunction : conv_cycles

	logic [15:0]  setup_reg;
	logic [15:0]  setup_next;
	logic [15:0]  shunt_reg;
	logic [7:0]   ptr_reg;
	logic         hi_phase_reg;
	logic [7:0]   wr_hi_reg;
	logic         wr_phase_reg;
	logic [16:0]  samp_s1_reg;
	logic [16:0]  samp_s2_reg;
	logic [23:0]  cnt_reg;
	logic         chan_reg;
	logic         trig_reg;
	logic [7:0]   rd_byte_reg;
	logic         shunt_pulse_reg;
	logic         bus_pulse_reg;
	mon_state_t   state_reg;
	mon_state_t   state_next;

	wire logic        soft_rst;
	wire logic        setup_wr;
	wire logic [1:0]  shunt_gain_select;
	wire logic        bus_range_select;
	wire logic [3:0]  bus_conv_setting;
	wire logic [3:0]  shunt_conv_setting;
	wire mon_mode_t   mode;
	wire logic        mode_cont;
	wire logic        want_shunt;
	wire logic        want_bus;
	wire logic        can_run;
	wire logic [23:0] chan_len;
	wire logic        chan_end;
	wire logic [15:0] shunt_fmt;
	wire logic [15:0] rd_word;

	assign shunt_gain_select  = setup_reg[`MON_GAIN_HI:`MON_GAIN_LO];
	assign bus_range_select   = setup_reg[`MON_BIT_BUS_RANGE]; // [R02]
	assign bus_conv_setting   =
		setup_reg[`MON_BUS_CONV_HI:`MON_BUS_CONV_LO]; // [R05]
	assign shunt_conv_setting =
		setup_reg[`MON_SHUNT_CONV_HI:`MON_SHUNT_CONV_LO]; // [R06]
	assign mode       = mon_mode_t'(setup_reg[`MON_MODE_HI:`MON_MODE_LO]);
	assign mode_cont  = mode[2];
	assign want_shunt = mode[0]; // [R10]
	assign want_bus   = mode[1]; // [R10]
	assign can_run    = (want_shunt | want_bus) & (mode_cont | trig_reg);

	// second byte of a write to pointer 00h commits the setup word
	assign setup_wr   = byte_wr & wr_phase_reg & (ptr_reg == `MON_PTR_SETUP);
	assign setup_next = {wr_hi_reg, byte_wdata};
	assign soft_rst   = setup_wr & setup_next[`MON_BIT_SOFT_RST]; // [R01]

	// channel 0 shunt, 1 bus; one conversion time each
	assign chan_len = chan_reg ? conv_cycles(bus_conv_setting)
	                           : conv_cycles(shunt_conv_setting);
	assign chan_end = (state_reg == MON_ST_CONV) && (cnt_reg == chan_len);

	mon_shunt_fmt u_fmt (
		.shunt_gain_select (shunt_gain_select),
		.raw_sample        (samp_s2_reg),
		.result            (shunt_fmt)
	);

	assign rd_word = (ptr_reg == `MON_PTR_SETUP) ? setup_reg :
	                 (ptr_reg == `MON_PTR_SHUNT) ? shunt_reg :
	                 16'h0000;

	always_comb begin
		state_next = state_reg;
		case (state_reg)
			MON_ST_IDLE: begin
				if (can_run)
					state_next = MON_ST_CONV;
			end
			MON_ST_CONV: begin
				if (!can_run && !trig_reg)
					state_next = MON_ST_IDLE;
				else if (chan_end && (chan_reg || !want_bus))
					state_next = MON_ST_DONE;
			end
			MON_ST_DONE: state_next = MON_ST_IDLE;
			default:     state_next = MON_ST_IDLE;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			samp_s1_reg <= 17'h00000;
			samp_s2_reg <= 17'h00000;
		end else begin
			samp_s1_reg <= shunt_sample;
			samp_s2_reg <= samp_s1_reg;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			setup_reg    <= `MON_SETUP_RESET; // [R02] [R04] [R09]
			ptr_reg      <= 8'h00;
			wr_hi_reg    <= 8'h00;
			wr_phase_reg <= 1'b0;
		end else if (soft_rst) begin
			setup_reg    <= `MON_SETUP_RESET; // [R01]
			ptr_reg      <= 8'h00;
			wr_hi_reg    <= 8'h00;
			wr_phase_reg <= 1'b0;
		end else begin
			if (ptr_wr) begin
				ptr_reg      <= ptr_data;
				wr_phase_reg <= 1'b0;
			end else if (byte_wr) begin
				wr_phase_reg <= ~wr_phase_reg;
				if (!wr_phase_reg)
					wr_hi_reg <= byte_wdata; // [R19]
			end
			if (setup_wr)
				setup_reg <= setup_next;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_reg       <= MON_ST_IDLE;
			cnt_reg         <= 24'h000000;
			chan_reg        <= 1'b0;
			trig_reg        <= 1'b0;
			shunt_reg       <= 16'h0000;
			shunt_pulse_reg <= 1'b0;
			bus_pulse_reg   <= 1'b0;
		end else if (soft_rst) begin
			state_reg       <= MON_ST_IDLE;
			cnt_reg         <= 24'h000000;
			chan_reg        <= 1'b0;
			trig_reg        <= 1'b0;
			shunt_reg       <= 16'h0000;
			shunt_pulse_reg <= 1'b0;
			bus_pulse_reg   <= 1'b0;
		end else begin
			state_reg       <= state_next;
			shunt_pulse_reg <= 1'b0;
			bus_pulse_reg   <= 1'b0;
			if (setup_wr && !setup_next[`MON_MODE_HI])
				trig_reg <= 1'b1; // [R20]
			else if (state_reg == MON_ST_DONE || setup_wr)
				trig_reg <= 1'b0; // [R20]
			if (state_reg != MON_ST_CONV || setup_wr) begin
				cnt_reg  <= 24'h000001;
				chan_reg <= ~want_shunt;
			end else if (chan_end) begin
				cnt_reg <= 24'h000001;
				if (!chan_reg) begin
					shunt_reg       <= shunt_fmt; // [R11] [R12]
					shunt_pulse_reg <= 1'b1;
					chan_reg        <= want_bus ? 1'b1 : 1'b0;
				end else begin
					bus_pulse_reg <= 1'b1;
					chan_reg      <= ~want_shunt;
				end
			end else begin
				cnt_reg <= cnt_reg + 24'h000001;
			end
		end
	end

	// read port: high byte at read start, low byte after it
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rd_byte_reg  <= 8'h00;
			hi_phase_reg <= 1'b0;
		end else if (rd_start) begin
			rd_byte_reg  <= rd_word[15:8]; // [R19]
			hi_phase_reg <= 1'b1;
		end else if (byte_rd) begin
			rd_byte_reg  <= hi_phase_reg ? rd_word[7:0] : rd_word[15:8]; // [R19]
			hi_phase_reg <= ~hi_phase_reg;
		end
	end

	assign rd_byte          = rd_byte_reg;
	assign setup_reg_out    = setup_reg;
	assign mode_out         = mode;
	assign conv_busy        = (state_reg == MON_ST_CONV);
	assign shunt_conv_pulse = shunt_pulse_reg;
	assign bus_conv_pulse   = bus_pulse_reg;

	a_soft_rst_clears: assert property (@(posedge clk) disable iff (rst)
		soft_rst |=> setup_reg == `MON_SETUP_RESET) // [R01]
		else $error("soft reset did not restore setup word");
	a_rst_bit_low: assert property (@(posedge clk) disable iff (rst)
		!setup_reg[`MON_BIT_SOFT_RST]) // [R01]
		else $error("reset bit stayed set");
	a_shunt_in_range: assert property (@(posedge clk) disable iff (rst)
		$signed(shunt_reg) <= $signed(16'h7D00)
		&& $signed(shunt_reg) >= $signed(16'h8300)) // [R18]
		else $error("shunt result beyond full scale");
	a_gain_sign_bits: assert property (@(posedge clk) disable iff (rst)
		shunt_pulse_reg && shunt_gain_select == 2'h0
		|-> shunt_reg[15:12] == {4{shunt_reg[15]}}) // [R12]
		else $error("sign bits differ at unity gain");
	a_unity_clamp: assert property (@(posedge clk) disable iff (rst)
		shunt_pulse_reg && shunt_gain_select == 2'h0
		|-> $signed(shunt_reg) <= $signed(16'h0FA0)
		&& $signed(shunt_reg) >= $signed(16'hF060)) // [R17]
		else $error("shunt result beyond unity full scale");
	a_div2_clamp: assert property (@(posedge clk) disable iff (rst)
		shunt_pulse_reg && shunt_gain_select == 2'h1
		|-> $signed(shunt_reg) <= $signed(16'h1F40)
		&& $signed(shunt_reg) >= $signed(16'hE0C0)) // [R16]
		else $error("shunt result beyond half full scale");
	a_div4_clamp: assert property (@(posedge clk) disable iff (rst)
		shunt_pulse_reg && shunt_gain_select == 2'h2
		|-> $signed(shunt_reg) <= $signed(16'h3E80)
		&& $signed(shunt_reg) >= $signed(16'hC180)) // [R15]
		else $error("shunt result beyond quarter full scale");
	a_trig_arms: assert property (@(posedge clk) disable iff (rst)
		setup_wr && !setup_next[`MON_MODE_HI] && !soft_rst
		|=> trig_reg) // [R20]
		else $error("triggered write did not arm a conversion");
	a_bus_updates: assert property (@(posedge clk) disable iff (rst)
		chan_end && chan_reg && !setup_wr |=> bus_pulse_reg) // [R05]
		else $error("bus conversion end not flagged");
	a_adc_off_idle: assert property (@(posedge clk) disable iff (rst)
		mode == MON_ADC_OFF && !setup_wr |=> state_reg != MON_ST_CONV) // [R10]
		else $error("conversion while adc disabled");
	a_cont_starts: assert property (@(posedge clk) disable iff (rst)
		state_reg == MON_ST_IDLE && can_run && !setup_wr
		|=> conv_busy) // [R10]
		else $error("enabled conversion did not start");
	a_powerdown_idle: assert property (@(posedge clk) disable iff (rst)
		mode == MON_POWER_DOWN && !setup_wr |=> state_reg != MON_ST_CONV) // [R10]
		else $error("conversion while powered down");
	a_trig_one_set: assert property (@(posedge clk) disable iff (rst)
		state_reg == MON_ST_DONE && !mode_cont && !setup_wr
		|=> !trig_reg ##1 state_reg == MON_ST_IDLE) // [R20]
		else $error("triggered mode did not stop");
	a_shunt_updates: assert property (@(posedge clk) disable iff (rst)
		chan_end && !chan_reg && !setup_wr |=> shunt_pulse_reg) // [R11]
		else $error("shunt result not stored");
	a_read_msb_first: assert property (@(posedge clk) disable iff (rst)
		rd_start |=> rd_byte == $past(rd_word[15:8])) // [R19]
		else $error("high byte not first");
	a_range_default: assert property (@(posedge clk) disable iff (rst)
		$rose(soft_rst) |=> bus_range_select
		&& shunt_gain_select == 2'h3 && mode == MON_CONT_BOTH) // [R02]
		else $error("defaults wrong after soft reset");
endmodule : mon_cfg_shunt

//--- src/mon_pkg.sv
/*
 * types of the monitor configuration and shunt result block.
 * assumes: nothing beyond the constants header.
 */
package mon_pkg;
	typedef enum logic [2:0] {
		MON_POWER_DOWN = 3'h0,
		MON_TRIG_SHUNT = 3'h1,
		MON_TRIG_BUS   = 3'h2,
		MON_TRIG_BOTH  = 3'h3,
		MON_ADC_OFF    = 3'h4,
		MON_CONT_SHUNT = 3'h5,
		MON_CONT_BUS   = 3'h6,
		MON_CONT_BOTH  = 3'h7
	} mon_mode_t;
	typedef enum logic [1:0] {
		MON_ST_IDLE = 2'b00,
		MON_ST_CONV = 2'b01,
		MON_ST_DONE = 2'b11
	} mon_state_t;
endpackage : mon_pkg

//--- src/mon_shunt_fmt.sv
/*
 * shunt result formatter: clamps a raw signed 10 uV sample to the
 * full scale of the selected gain and keeps its low 16 bits.
 * assumes: raw sample is two's complement, same clock domain.
 */
`include "mon_cfg_regs.svh"
module mon_shunt_fmt (
	input  wire logic [1:0]  shunt_gain_select,
	input  wire logic [16:0] raw_sample,
	output logic      [15:0] result
);
	import mon_pkg::*;
	wire logic [15:0] fs_pos;
	wire logic [16:0] pos17;
	wire logic [16:0] neg17;
	wire logic        over;
	wire logic        under;

	// full scale per gain: 00 x1, 01 /2, 10 /4, 11 /8
	assign fs_pos = (shunt_gain_select == 2'h3) ? `MON_FS_DIV8 :
	                (shunt_gain_select == 2'h2) ? `MON_FS_DIV4 :
	                (shunt_gain_select == 2'h1) ? `MON_FS_DIV2 :
	                `MON_FS_UNITY; // [R03] [R14] [R15] [R16] [R17]
	assign pos17 = {1'b0, fs_pos};
	assign neg17 = 17'h0 - pos17;
	assign over  = $signed(raw_sample) > $signed(pos17); // [R18]
	assign under = $signed(raw_sample) < $signed(neg17); // [R18]
	// low 16 bits of a clamped value hold all sign bits equal
	assign result = over  ? pos17[15:0] :
	                under ? neg17[15:0] :
	                raw_sample[15:0]; // [R12] [R13]
endmodule : mon_shunt_fmt

//--- test/macsr_host_model.sv
/*
 * byte-level model of the serial host: pointer set, word write, word read.
 * assumes: dut byte port on clk; strobes change 1 ns after a rising edge.
 */
module macsr_host_model (
	input  wire logic       clk,
	output logic            ptr_wr,
	output logic      [7:0] ptr_data,
	output logic            byte_wr,
	output logic      [7:0] byte_wdata,
	output logic            rd_start,
	output logic            byte_rd,
	input  wire logic [7:0] rd_byte
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		ptr_wr = 1'b0;
		ptr_data = 8'hA5;
		byte_wr = 1'b0;
		byte_wdata = 8'h5A;
		rd_start = 1'b0;
		byte_rd = 1'b0;
	end
	// released bytes show the inverse, never a stale value
	task automatic put_ptr(input logic [7:0] p);
		@(posedge clk) #1;
		ptr_wr = 1'b1;
		ptr_data = p;
		@(posedge clk) #1;
		ptr_wr = 1'b0;
		ptr_data = ~p;
	endtask : put_ptr
	task automatic wr(input logic [7:0] p, input logic [15:0] w);
		put_ptr(p);
		byte_wr = 1'b1;
		byte_wdata = w[15:8];
		@(posedge clk) #1;
		byte_wdata = w[7:0];
		@(posedge clk) #1;
		byte_wr = 1'b0;
		byte_wdata = ~w[7:0];
		@(posedge clk) #1;
	endtask : wr
	task automatic rd(input logic [7:0] p, output logic [15:0] w);
		put_ptr(p);
		rd_start = 1'b1;
		@(posedge clk) #1;
		rd_start = 1'b0;
		byte_rd = 1'b1;
		w[15:8] = rd_byte;
		@(posedge clk) #1;
		byte_rd = 1'b0;
		w[7:0] = rd_byte;
	endtask : rd
endmodule : macsr_host_model

//--- test/monitor_adc_config_shunt_result_bench.sv
/*
 * self-checking bench: setup word, triggered shunt conversions, clamping,
 * refused accesses, mode codes and soft reset.
 * assumes: mon_cfg_shunt and macsr_host_model compiled before.
 */
module monitor_adc_config_shunt_result_bench;
	timeunit 1ns;
	timeprecision 1ps;
	import mon_pkg::*;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        ptr_wr, byte_wr, rd_start, byte_rd;
	logic [7:0]  ptr_data, byte_wdata, rd_byte;
	logic [16:0] shunt_sample = 17'h00000;
	logic [15:0] setup_reg_out, w;
	mon_mode_t   mode_out;
	logic        conv_busy, shunt_conv_pulse, bus_conv_pulse;
	int          n_mismatch = 0;
	int          checks_done = 0;
	int          cycles = 0;
	always #4 clk = ~clk;
	mon_cfg_shunt DUT (
		.clk(clk), .rst(rst), .ptr_wr(ptr_wr), .ptr_data(ptr_data),
		.byte_wr(byte_wr), .byte_wdata(byte_wdata), .rd_start(rd_start),
		.byte_rd(byte_rd), .shunt_sample(shunt_sample), .rd_byte(rd_byte),
		.setup_reg_out(setup_reg_out), .mode_out(mode_out),
		.conv_busy(conv_busy), .shunt_conv_pulse(shunt_conv_pulse),
		.bus_conv_pulse(bus_conv_pulse)
	);
	macsr_host_model host (
		.clk(clk), .ptr_wr(ptr_wr), .ptr_data(ptr_data), .byte_wr(byte_wr),
		.byte_wdata(byte_wdata), .rd_start(rd_start), .byte_rd(byte_rd),
		.rd_byte(rd_byte)
	);
	task automatic close_out();
		$display("mismatches %0d checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 70000) begin
			n_mismatch++;
			close_out();
		end
	end
	// one triggered shunt conversion, then read it back
	task automatic conv(input logic [1:0] g, input logic [3:0] s,
		input logic [16:0] smp, input logic [15:0] exp);
		int n;
		logic [15:0] r;
		shunt_sample = smp;
		host.wr(8'h00, {3'b001, g, 4'h0, s, 3'b001});
		n = 0;
		while (shunt_conv_pulse !== 1'b1 && n < 12000) begin
			@(posedge clk) #1;
			n++;
		end
		chk(16'(n > 10300 && n < 10600), 16'h0001);
		n = 0;
		repeat (60) begin
			@(posedge clk) #1;
			if (shunt_conv_pulse !== 1'b0 || bus_conv_pulse !== 1'b0)
				n++;
		end
		chk(16'(n), 16'h0000);
		chk({15'h0000, conv_busy}, 16'h0000);
		host.rd(8'h01, r);
		chk(r, exp);
	endtask : conv
	initial begin
		repeat (6) @(posedge clk);
		#1 rst = 1'b0;
		host.rd(8'h00, w);
		chk(w, 16'h399F);
		chk(setup_reg_out, 16'h399F);
		conv(2'b11, 4'h0, 17'h07D02, 16'h7D00);
		conv(2'b11, 4'h4, 17'h1FFFE, 16'hFFFE);
		conv(2'b10, 4'h0, 17'h1C17F, 16'hC180);
		conv(2'b01, 4'h0, 17'h01F41, 16'h1F40);
		conv(2'b00, 4'h0, 17'h1F05F, 16'hF060);
		host.wr(8'h01, 16'h1234);
		host.rd(8'h01, w);
		chk(w, 16'hF060);
		host.rd(8'h05, w);
		chk(w, 16'h0000);
		for (int m = 0; m < 8; m++) begin
			host.wr(8'h00, {5'b00010, 4'hA, 4'h5, 3'(m)});
			chk(setup_reg_out, {5'b00010, 4'hA, 4'h5, 3'(m)});
			chk(16'(mode_out), 16'(m));
		end
		host.rd(8'h00, w);
		chk(w, 16'h152F);
		host.wr(8'h00, 16'h8000);
		chk(setup_reg_out, 16'h399F);
		host.rd(8'h00, w);
		chk(w, 16'h399F);
		host.rd(8'h01, w);
		chk(w, 16'h0000);
		close_out();
	end
endmodule : monitor_adc_config_shunt_result_bench
